/* src/spfrx_regs.vh */
// register map, field positions, reset values and timing counts of the serial port
`ifndef SPFRX_REGS_VH
`define SPFRX_REGS_VH
// byte offsets on the register bus
`define SPFRX_OFF_DATA      8'h00
`define SPFRX_OFF_STATUS    8'h04
`define SPFRX_OFF_CONTROL   8'h08
`define SPFRX_OFF_FORMAT    8'h0c
`define SPFRX_OFF_BAUD      8'h10
// status_reg_a bits
`define SPFRX_ST_RXC        7
`define SPFRX_ST_TXC        6
`define SPFRX_ST_UDRE       5
`define SPFRX_ST_FE         4
`define SPFRX_ST_DOR        3
`define SPFRX_ST_PE         2
// control_reg_b bits
`define SPFRX_CT_RXEN       0
`define SPFRX_CT_TRANSMITTER_ENABLE       1
`define SPFRX_CT_RXCIE      2
`define SPFRX_CT_TXCIE      3
`define SPFRX_CT_UDRIE      4
`define SPFRX_CT_TX9        5
`define SPFRX_CT_RX9        6
// format bits
`define SPFRX_FM_SIZE_LO    0
`define SPFRX_FM_SIZE_HI    2
`define SPFRX_FM_PAREN      3
`define SPFRX_FM_PARODD     4
`define SPFRX_FM_STOP2      5
`define SPFRX_FM_SYNC       6
// reset values
`define SPFRX_RST_SIZE      3'h3
`define SPFRX_RST_BAUD      12'h00c
// character size code for nine data bits
`define SPFRX_SIZE_NINE     3'h7
// oversampling: last sub-bit index and the three voting samples
`define SPFRX_SUB_LAST      4'hf
`define SPFRX_VOTE_A        4'h7
`define SPFRX_VOTE_B        4'h8
`define SPFRX_VOTE_C        4'h9
`endif

/* src/spfrx_top.v */
// serial port: transmit flags, parity insertion, receive buffer and flags behind an ahb-lite slave
`default_nettype none
`include "spfrx_regs.vh"

module spfrx_top (
  input  wire        mclk,                 // system clock
  input  wire        resetn,               // async reset, active low
  input  wire        hsel,                 // slave select
  input  wire [31:0] haddr,                // byte address
  input  wire [1:0]  htrans,               // transfer type
  input  wire        hwrite,               // write not read
  input  wire [2:0]  hsize,                // transfer size
  input  wire [31:0] hwdata,               // write data
  input  wire        hready,               // bus ready
  output reg         hreadyout,            // slave ready
  output reg         hresp,                // response, always okay
  output reg  [31:0] hrdata,               // read data
  input  wire        serial_in_pin,        // receive line
  input  wire        transfer_clock_pin,   // external transfer clock
  input  wire        tx_complete_irq_ack,  // transmit-complete interrupt taken
  output reg         serial_out_pin,       // transmit line
  output reg         serial_out_override,  // high while transmitter owns pin
  output reg         serial_in_override,   // high while receiver owns pin
  output reg         irq_rx_complete,      // receive-complete request
  output reg         irq_tx_buffer_empty,  // buffer-empty request
  output reg         irq_tx_complete       // transmit-complete request
);
  localparam RX_IDLE  = 2'h0;
  localparam RX_START = 2'h1;
  localparam RX_DATA  = 2'h2;

  reg  [1:0]  rst_sync;
  reg  [1:0]  rxd_sync;
  reg  [1:0]  xck_sync;
  reg         xck_prev;
  reg         rxd_prev;
  reg  [11:0] baud_cnt;
  reg         wr_pend;
  reg  [7:0]  wr_addr;
  reg         receiver_enable;
  reg         transmitter_enable;
  reg         rx_complete_irq_en;
  reg         tx_complete_irq_en;
  reg         tx_buffer_empty_irq_en;
  reg         tx_ninth_bit;
  reg  [2:0]  char_size_field;
  reg         parity_enable_bit;
  reg         parity_odd;
  reg         two_stop;
  reg         sync_mode;
  reg  [11:0] baud_div;
  reg  [8:0]  tx_hold;
  reg         tx_buffer_empty_flag;
  reg         tx_complete_flag;
  reg         tx_busy;
  reg         tx_on;
  reg  [12:0] tx_shift;
  reg  [3:0]  tx_left;
  reg  [3:0]  tx_sub;
  reg  [11:0] tx_frame;
  reg         tx_par;
  reg  [1:0]  rx_state;
  reg  [3:0]  rx_sub;
  reg  [1:0]  rx_votes;
  reg  [3:0]  rx_cnt;
  reg  [10:0] rx_shift;
  reg  [10:0] rx_cur;
  reg  [11:0] rx_fifo [0:1];
  reg         rx_rd_ptr;
  reg         rx_wr_ptr;
  reg  [1:0]  rx_count;
  reg  [11:0] rx_wait;
  reg         rx_wait_v;
  reg         rx_lost;
  reg  [31:0] next_hrdata;
  integer     i;

  wire        rst_n = rst_sync[1];
  wire        rxd = rxd_sync[1];
  wire        xck = xck_sync[1];
  wire        xck_rise = xck & ~xck_prev;
  wire        xck_fall = ~xck & xck_prev;
  wire        baud_tick = (baud_cnt == 12'h000);
  wire        ahb_take = hsel & htrans[1] & hready;
  wire        rd_data = ahb_take & ~hwrite & (haddr[7:0] == `SPFRX_OFF_DATA);
  wire        wr_data = wr_pend & (wr_addr == `SPFRX_OFF_DATA);
  wire        wr_status = wr_pend & (wr_addr == `SPFRX_OFF_STATUS);
  wire        wr_control = wr_pend & (wr_addr == `SPFRX_OFF_CONTROL);
  wire        wr_format = wr_pend & (wr_addr == `SPFRX_OFF_FORMAT);
  wire        wr_baud = wr_pend & (wr_addr == `SPFRX_OFF_BAUD);

  // frame geometry from the character size code
  wire [3:0]  nbits = (char_size_field == `SPFRX_SIZE_NINE) ? 4'h9 :
                      (char_size_field < 3'h4) ? ({1'b0, char_size_field} + 4'h5) : 4'h8;
  wire [8:0]  data_mask = ~(9'h1ff << nbits);
  wire [3:0]  tx_len = nbits + {3'h0, parity_enable_bit} + (two_stop ? 4'h2 : 4'h1) + 4'h1;
  wire [3:0]  rx_need = nbits + {3'h0, parity_enable_bit} + 4'h1;

  // reset release through two flops
  always @(posedge mclk or negedge resetn) begin
    if (!resetn)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end

  // pin synchronisers; only the second stage is looked at
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rxd_sync <= 2'h3;
      xck_sync <= 2'h0;
      rxd_prev <= 1'b1;
      xck_prev <= 1'b0;
    end else begin
      rxd_sync <= {rxd_sync[0], serial_in_pin};
      xck_sync <= {xck_sync[0], transfer_clock_pin};
      rxd_prev <= rxd;
      xck_prev <= xck;
    end
  end

  // oversampling tick, sixteen per bit
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      baud_cnt <= 12'h000;
    else if (baud_tick)
      baud_cnt <= baud_div;
    else
      baud_cnt <= baud_cnt - 12'h001;
  end

  // ahb-lite address phase capture; zero wait states
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend   <= 1'b0;
      wr_addr   <= 8'h00;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
    end else begin
      wr_pend   <= ahb_take & hwrite;
      wr_addr   <= haddr[7:0];
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (ahb_take & ~hwrite)
        hrdata <= next_hrdata;
    end
  end

  // control and format registers, written in the data phase
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      receiver_enable        <= 1'b0;
      transmitter_enable     <= 1'b0;
      rx_complete_irq_en     <= 1'b0;
      tx_complete_irq_en     <= 1'b0;
      tx_buffer_empty_irq_en <= 1'b0;
      tx_ninth_bit           <= 1'b0;
      char_size_field        <= `SPFRX_RST_SIZE;
      parity_enable_bit      <= 1'b0;
      parity_odd             <= 1'b0;
      two_stop               <= 1'b0;
      sync_mode              <= 1'b0;
      baud_div               <= `SPFRX_RST_BAUD;
    end else begin
      if (wr_control) begin
        receiver_enable        <= hwdata[`SPFRX_CT_RXEN];
        transmitter_enable     <= hwdata[`SPFRX_CT_TRANSMITTER_ENABLE];
        rx_complete_irq_en     <= hwdata[`SPFRX_CT_RXCIE];
        tx_complete_irq_en     <= hwdata[`SPFRX_CT_TXCIE];
        tx_buffer_empty_irq_en <= hwdata[`SPFRX_CT_UDRIE];
        tx_ninth_bit           <= hwdata[`SPFRX_CT_TX9];
      end
      if (wr_format) begin
        char_size_field   <= hwdata[`SPFRX_FM_SIZE_HI:`SPFRX_FM_SIZE_LO];
        parity_enable_bit <= hwdata[`SPFRX_FM_PAREN];
        parity_odd        <= hwdata[`SPFRX_FM_PARODD];
        two_stop          <= hwdata[`SPFRX_FM_STOP2];
        sync_mode         <= hwdata[`SPFRX_FM_SYNC];
      end
      if (wr_baud)
        baud_div <= hwdata[11:0];
    end
  end

  // transmit frame image: data, optional parity, then stop ones
  always @* begin
    tx_par = (^(tx_hold & data_mask)) ^ parity_odd;
    tx_frame = 12'hfff;
    for (i = 0; i < 12; i = i + 1) begin
      if (i < nbits)
        tx_frame[i] = tx_hold[i % 9];
      else if ((i == nbits) && parity_enable_bit)
        tx_frame[i] = tx_par;
    end
  end

  wire tx_step = sync_mode ? xck_fall : (baud_tick && (tx_sub == `SPFRX_SUB_LAST));
  wire tx_last = tx_busy & tx_step & (tx_left == 4'h1);
  wire tx_load = tx_on & ~tx_buffer_empty_flag & (~tx_busy | tx_last);

  // transmit path: holding buffer, shifter and both flags
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_hold              <= 9'h000;
      tx_buffer_empty_flag <= 1'b1;
      tx_complete_flag     <= 1'b0;
      tx_busy              <= 1'b0;
      tx_on                <= 1'b0;
      tx_shift             <= 13'h1fff;
      tx_left              <= 4'h0;
      tx_sub               <= 4'h0;
      serial_out_pin       <= 1'b1;
      serial_out_override  <= 1'b0;
    end else begin
      // pending data keeps the transmitter alive after enable drops
      tx_on <= transmitter_enable | (tx_on & (tx_busy | ~tx_buffer_empty_flag));
      serial_out_override <= tx_on;
      serial_out_pin <= tx_busy ? tx_shift[0] : 1'b1;
      if (baud_tick)
        tx_sub <= tx_sub + 4'h1;
      if (tx_load) begin
        tx_shift <= {tx_frame, 1'b0};
        tx_left  <= tx_len;
        tx_busy  <= 1'b1;
        tx_sub   <= 4'h0;
        tx_buffer_empty_flag <= 1'b1;
      end else if (tx_last) begin
        tx_busy <= 1'b0;
      end else if (tx_busy & tx_step) begin
        tx_shift <= {1'b1, tx_shift[12:1]};
        tx_left  <= tx_left - 4'h1;
      end
      // a late write still lands in the holding buffer
      if (wr_data) begin
        tx_hold <= {tx_ninth_bit, hwdata[7:0]};
        tx_buffer_empty_flag <= 1'b0;
      end
      // set beats clear when they meet
      if (tx_last & ~tx_load)
        tx_complete_flag <= 1'b1;
      else if (tx_complete_irq_ack)
        tx_complete_flag <= 1'b0;
      else if (wr_status & hwdata[`SPFRX_ST_TXC])
        tx_complete_flag <= 1'b0;
    end
  end

  // receive bit strobe: majority of three in async, transfer clock edge in sync
  wire rx_maj = (rx_votes[1] & rx_votes[0]) | (rx_votes[1] & rxd) | (rx_votes[0] & rxd);
  wire rx_strobe = sync_mode ? xck_rise : (baud_tick && (rx_sub == `SPFRX_VOTE_C));
  wire rx_val = sync_mode ? rxd : rx_maj;
  wire rx_fall = ~rxd & rxd_prev;
  wire rx_begin = (rx_state == RX_IDLE) & (sync_mode ? (rx_strobe & ~rx_val) : rx_fall);
  wire rx_done = (rx_state == RX_DATA) & rx_strobe & (rx_cnt == rx_need - 4'h1);

  // receive frame image with the current bit in place
  always @* begin
    rx_cur = rx_shift;
    rx_cur[rx_cnt] = rx_val;
  end

  wire [8:0]  rx_dat = rx_cur[8:0] & data_mask;
  wire        rx_par = rx_cur[nbits];
  wire        rx_stop = rx_cur[nbits + {3'h0, parity_enable_bit}];
  wire        rx_pe = parity_enable_bit & (rx_par != ((^rx_dat) ^ parity_odd));
  wire [11:0] rx_entry = {rx_pe, rx_lost, ~rx_stop, rx_dat};
  wire        rx_pop = rd_data & (rx_count != 2'h0);
  wire        rx_space = (rx_count != 2'h2) | rx_pop;
  wire        rx_push_wait = rx_wait_v & rx_space;
  wire        rx_push_new = rx_done & rx_space & ~rx_wait_v;
  wire        rx_push = rx_push_wait | rx_push_new;
  wire [11:0] rx_head = rx_fifo[rx_rd_ptr];
  wire        rx_complete_flag = (rx_count != 2'h0);

  // receiver sequencer and two-entry buffer
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_state   <= RX_IDLE;
      rx_sub     <= 4'h0;
      rx_votes   <= 2'h3;
      rx_cnt     <= 4'h0;
      rx_shift   <= 11'h000;
      rx_fifo[0] <= 12'h000;
      rx_fifo[1] <= 12'h000;
      rx_rd_ptr  <= 1'b0;
      rx_wr_ptr  <= 1'b0;
      rx_count   <= 2'h0;
      rx_wait    <= 12'h000;
      rx_wait_v  <= 1'b0;
      rx_lost    <= 1'b0;
      serial_in_override <= 1'b0;
    end else if (!receiver_enable) begin
      // disable is immediate and drops everything held
      rx_state  <= RX_IDLE;
      rx_count  <= 2'h0;
      rx_rd_ptr <= 1'b0;
      rx_wr_ptr <= 1'b0;
      rx_wait_v <= 1'b0;
      rx_lost   <= 1'b0;
      serial_in_override <= 1'b0;
    end else begin
      serial_in_override <= 1'b1;
      if (baud_tick) begin
        rx_sub <= rx_sub + 4'h1;
        if ((rx_sub == `SPFRX_VOTE_A) || (rx_sub == `SPFRX_VOTE_B))
          rx_votes <= {rx_votes[0], rxd};
      end
      case (rx_state)
        RX_IDLE: begin
          if (rx_begin) begin
            rx_cnt <= 4'h0;
            rx_sub <= 4'h0;
            rx_state <= sync_mode ? RX_DATA : RX_START;
          end
        end
        RX_START: begin
          // a high majority at mid start is a spike
          if (rx_strobe)
            rx_state <= rx_val ? RX_IDLE : RX_DATA;
        end
        RX_DATA: begin
          if (rx_strobe) begin
            rx_shift[rx_cnt] <= rx_val;
            rx_cnt <= rx_cnt + 4'h1;
            if (rx_done)
              rx_state <= RX_IDLE;
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
      // a start while a third frame waits loses that frame
      if (rx_begin & rx_wait_v & ~rx_push_wait) begin
        rx_wait_v <= 1'b0;
        rx_lost   <= 1'b1;
      end else if (rx_push_wait) begin
        rx_wait_v <= rx_done;
        rx_wait   <= rx_entry;
      end else if (rx_done & ~rx_push_new) begin
        rx_wait   <= rx_entry;
        rx_wait_v <= 1'b1;
        rx_lost   <= rx_lost | rx_wait_v;
      end
      if (rx_push) begin
        rx_fifo[rx_wr_ptr] <= rx_push_wait ? rx_wait : rx_entry;
        rx_wr_ptr <= ~rx_wr_ptr;
        if (rx_push_new)
          rx_lost <= 1'b0;
      end
      if (rx_pop)
        rx_rd_ptr <= ~rx_rd_ptr;
      rx_count <= rx_count + {1'b0, rx_push} - {1'b0, rx_pop};
    end
  end

  // read mux; status and ninth bit show the oldest entry
  always @* begin
    next_hrdata = 32'h0000_0000;
    case (haddr[7:0])
      `SPFRX_OFF_DATA:
        next_hrdata[7:0] = rx_complete_flag ? rx_head[7:0] : 8'h00;
      `SPFRX_OFF_STATUS: begin
        next_hrdata[`SPFRX_ST_RXC]  = rx_complete_flag;
        next_hrdata[`SPFRX_ST_TXC]  = tx_complete_flag;
        next_hrdata[`SPFRX_ST_UDRE] = tx_buffer_empty_flag;
        next_hrdata[`SPFRX_ST_FE]   = rx_complete_flag & rx_head[9];
        next_hrdata[`SPFRX_ST_DOR]  = rx_complete_flag & rx_head[10];
        next_hrdata[`SPFRX_ST_PE]   = rx_complete_flag & rx_head[11];
      end
      `SPFRX_OFF_CONTROL: begin
        next_hrdata[`SPFRX_CT_RXEN]  = receiver_enable;
        next_hrdata[`SPFRX_CT_TRANSMITTER_ENABLE]  = transmitter_enable;
        next_hrdata[`SPFRX_CT_RXCIE] = rx_complete_irq_en;
        next_hrdata[`SPFRX_CT_TXCIE] = tx_complete_irq_en;
        next_hrdata[`SPFRX_CT_UDRIE] = tx_buffer_empty_irq_en;
        next_hrdata[`SPFRX_CT_TX9]   = tx_ninth_bit;
        next_hrdata[`SPFRX_CT_RX9]   = rx_complete_flag & rx_head[8];
      end
      `SPFRX_OFF_FORMAT: begin
        next_hrdata[`SPFRX_FM_SIZE_HI:`SPFRX_FM_SIZE_LO] = char_size_field;
        next_hrdata[`SPFRX_FM_PAREN]  = parity_enable_bit;
        next_hrdata[`SPFRX_FM_PARODD] = parity_odd;
        next_hrdata[`SPFRX_FM_STOP2]  = two_stop;
        next_hrdata[`SPFRX_FM_SYNC]   = sync_mode;
      end
      `SPFRX_OFF_BAUD:
        next_hrdata[11:0] = baud_div;
      default:
        next_hrdata = 32'h0000_0000;
    endcase
  end

  // interrupt requests; global masking sits in the interrupt controller
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_rx_complete     <= 1'b0;
      irq_tx_buffer_empty <= 1'b0;
      irq_tx_complete     <= 1'b0;
    end else begin
      irq_rx_complete     <= rx_complete_flag & rx_complete_irq_en;
      irq_tx_buffer_empty <= tx_buffer_empty_flag & tx_buffer_empty_irq_en;
      irq_tx_complete     <= tx_complete_flag & tx_complete_irq_en;
    end
  end

endmodule
`default_nettype wire

/* dv/spfrx_monitor.sv */
// concurrent checks on the serial port's outputs, tied to a shadow of the control register
`default_nettype none
`include "spfrx_regs.vh"
module spfrx_monitor (
  input wire logic        mclk,                 // system clock
  input wire logic        resetn,               // async reset, active low
  input wire logic        hsel,                 // slave select
  input wire logic [31:0] haddr,                // byte address
  input wire logic [1:0]  htrans,               // transfer type
  input wire logic        hwrite,               // write not read
  input wire logic [31:0] hwdata,               // write data
  input wire logic        hready,               // bus ready
  input wire logic        serial_out_pin,       // transmit line
  input wire logic        serial_out_override,  // transmitter owns pin
  input wire logic        serial_in_override,   // receiver owns pin
  input wire logic        tx_complete_irq_ack,  // interrupt taken
  input wire logic        irq_rx_complete,      // receive-complete request
  input wire logic        irq_tx_buffer_empty,  // buffer-empty request
  input wire logic        irq_tx_complete       // transmit-complete request
);
  logic [6:0] ctl;     // control register as software last wrote it
  logic       ctl_wr;  // data phase of a control write
  wire        take    = hsel && htrans[1] && hready;
  wire        rd_data = take && !hwrite && haddr[7:0] == `SPFRX_OFF_DATA;
  // shadow updates on the same edge as the design's own register
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctl    <= 7'h00;
      ctl_wr <= 1'b0;
    end else begin
      ctl_wr <= take && hwrite && haddr[7:0] == `SPFRX_OFF_CONTROL;
      if (ctl_wr) ctl <= hwdata[6:0];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence s_rx_off; ctl_wr && !hwdata[0]; endsequence
  sequence s_rx_empty2; !irq_rx_complete [*2]; endsequence
  property p_rx_own; ctl_wr |-> ##[1:3] serial_in_override == ctl[0]; endproperty
  a_rx_own: assert property (p_rx_own) else $error("receive pin ownership wrong");
  property p_flush; s_rx_off |-> ##[1:3] s_rx_empty2; endproperty
  a_flush: assert property (p_flush) else $error("receive flag kept after disable");
  property p_bempty_mask; irq_tx_buffer_empty |-> $past(ctl[4]); endproperty
  a_bempty_mask: assert property (p_bempty_mask) else $error("buffer-empty request while masked");
  property p_txc_mask; irq_tx_complete |-> $past(ctl[3]); endproperty
  a_txc_mask: assert property (p_txc_mask) else $error("tx-complete request while masked");
  property p_rxc_mask; irq_rx_complete |-> $past(ctl[2]); endproperty
  a_rxc_mask: assert property (p_rxc_mask) else $error("rx-complete request while masked");
  property p_txoff_idle; !serial_out_override |-> serial_out_pin; endproperty
  a_txoff_idle: assert property (p_txoff_idle) else $error("line not idle after release");
  property p_txoff_order; $fell(serial_out_override) |-> !$past(ctl[1]) && $past(serial_out_pin); endproperty
  a_txoff_order: assert property (p_txoff_order) else $error("pin released mid-frame");
  property p_rxc_hold;
    irq_rx_complete && ctl[0] && ctl[2] && !ctl_wr && !rd_data && !$past(rd_data) |=> irq_rx_complete;
  endproperty
  a_rxc_hold: assert property (p_rxc_hold) else $error("rx-complete dropped without read");
  property p_txc_ack; irq_tx_complete && tx_complete_irq_ack |-> ##[1:3] !irq_tx_complete; endproperty
  a_txc_ack: assert property (p_txc_ack) else $error("tx-complete kept after ack");
endmodule
bind spfrx_top spfrx_monitor spfrx_monitor_i (.mclk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .hready, .serial_out_pin, .serial_out_override, .serial_in_override, .tx_complete_irq_ack,
  .irq_rx_complete, .irq_tx_buffer_empty, .irq_tx_complete);
`default_nettype wire

/* dv/spfrx_line_model.sv */
// remote serial station: sends frames to the port and captures what it transmits
`default_nettype none
module spfrx_line_model (
  input  wire logic mclk,     // system clock, paces the bit time
  input  wire logic tx_line,  // port's transmit line
  output logic      rx_line,  // port's receive line, idles high
  output logic      xck       // transfer clock, still outside frames
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned rx_nb;      // bits captured after start
  logic [11:0] cap_q[$];   // captured frames, lsb first
  initial begin
    rx_line = 1'b1;
    xck     = 1'b0;
    rx_nb   = 10;
  end
  // one frame: start, n bits lsb first, one stop; 16 mclk a bit at divisor zero
  task automatic send(input logic [11:0] v, input int n, input bit sync);
    logic [13:0] fr;
    fr = 14'h3fff;
    fr[0] = 1'b0;
    for (int i = 0; i < n; i++) fr[i+1] = v[i];
    for (int i = 0; i < n + 2; i++) begin
      @(posedge mclk);
      rx_line <= fr[i];
      repeat (7) @(posedge mclk);
      xck <= sync;
      repeat (8) @(posedge mclk);
      xck <= 1'b0;
    end
  endtask
  // sample mid-bit from the falling start edge
  initial begin
    logic [11:0] v;
    forever begin
      @(negedge tx_line);
      repeat (8) @(posedge mclk);
      v = 12'h000;
      for (int i = 0; i < rx_nb; i++) begin
        repeat (16) @(posedge mclk);
        v[i] = tx_line;
      end
      cap_q.push_back(v);
    end
  end
endmodule
`default_nettype wire

/* dv/spfrx_top_tb.sv */
// directed register-level tests of the serial port against the line model
`default_nettype none
`include "spfrx_regs.vh"
module spfrx_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, resetn, hsel, hwrite, tx_complete_irq_ack;
  logic [31:0] haddr, hwdata;
  logic [1:0]  htrans;
  wire         hreadyout, hresp, serial_in_pin, transfer_clock_pin, serial_out_pin, serial_out_override;
  wire         serial_in_override, irq_rx_complete, irq_tx_buffer_empty, irq_tx_complete;
  wire  [31:0] hrdata;
  int          err_total, n_compared;
  spfrx_top spfrx_top_i (.mclk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .serial_in_pin, .transfer_clock_pin,
    .tx_complete_irq_ack, .serial_out_pin, .serial_out_override, .serial_in_override,
    .irq_rx_complete, .irq_tx_buffer_empty, .irq_tx_complete);
  spfrx_line_model spfrx_line_model_i (.mclk, .tx_line(serial_out_pin), .rx_line(serial_in_pin),
    .xck(transfer_clock_pin));
  always #2.5 mclk = ~mclk;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // one single ahb-lite transfer; address held until hready, then data phase
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(a, 1'b1, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    xfer(a, 1'b0, 32'h0, q);
    chk(q & m, e);
  endtask
  task automatic summarize;
    $display("comparisons %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // hang guard, about seven times the expected run
  initial begin
    #100000;
    err_total++;
    $display("mismatch at %0t: watchdog expired", $time);
    summarize();
  end
  initial begin
    mclk = 0;
    resetn = 0;
    hsel = 0;
    hwrite = 0;
    haddr = 0;
    hwdata = 0;
    htrans = 0;
    tx_complete_irq_ack = 0;
    err_total = 0;
    n_compared = 0;
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    repeat (3) @(posedge mclk);
    rdc(`SPFRX_OFF_STATUS, 32'hffffffff, 32'h20);
    rdc(8'h14, 32'hffffffff, 32'h0);
    chk(hresp, 1'b0);
    wr(`SPFRX_OFF_BAUD, 32'h0);
    wr(`SPFRX_OFF_FORMAT, 32'h0b);
    wr(`SPFRX_OFF_CONTROL, 32'h1a);
    // back-to-back loads: second waits in the holding buffer
    wr(`SPFRX_OFF_DATA, 32'ha5);
    wr(`SPFRX_OFF_DATA, 32'h07);
    rdc(`SPFRX_OFF_STATUS, 32'hff, 32'h00);
    chk(irq_tx_buffer_empty, 1'b0);
    repeat (900) if (irq_tx_complete !== 1'b1) @(posedge mclk);
    chk(irq_tx_complete, 1'b1);
    chk(irq_tx_buffer_empty, 1'b1);
    chk(spfrx_line_model_i.cap_q[0], 12'h2a5);
    chk(spfrx_line_model_i.cap_q[1], 12'h307);
    rdc(`SPFRX_OFF_STATUS, 32'h60, 32'h60);
    @(posedge mclk) tx_complete_irq_ack <= 1'b1;
    @(posedge mclk) tx_complete_irq_ack <= 1'b0;
    rdc(`SPFRX_OFF_STATUS, 32'h60, 32'h20);
    wr(`SPFRX_OFF_DATA, 32'h55);
    repeat (900) if (irq_tx_complete !== 1'b1) @(posedge mclk);
    wr(`SPFRX_OFF_STATUS, 32'h00);
    rdc(`SPFRX_OFF_STATUS, 32'h60, 32'h60);
    wr(`SPFRX_OFF_STATUS, 32'h40);
    rdc(`SPFRX_OFF_STATUS, 32'h60, 32'h20);
    // disable with one frame sending and one pending
    wr(`SPFRX_OFF_DATA, 32'h81);
    wr(`SPFRX_OFF_DATA, 32'h18);
    wr(`SPFRX_OFF_CONTROL, 32'h00);
    chk(serial_out_override, 1'b1);
    repeat (900) if (serial_out_override !== 1'b0) @(posedge mclk);
    chk(spfrx_line_model_i.cap_q.size(), 5);
    chk(spfrx_line_model_i.cap_q[4], 12'h218);
    // nine-bit transmit: ninth bit set before the low byte goes in
    wr(`SPFRX_OFF_FORMAT, 32'h07);
    wr(`SPFRX_OFF_CONTROL, 32'h22);
    wr(`SPFRX_OFF_DATA, 32'h3c);
    repeat (400) if (spfrx_line_model_i.cap_q.size() < 6) @(posedge mclk);
    chk(spfrx_line_model_i.cap_q[5], 12'h33c);
    // five-bit character, top bits read as zero
    wr(`SPFRX_OFF_FORMAT, 32'h00);
    wr(`SPFRX_OFF_CONTROL, 32'h05);
    repeat (2) @(posedge mclk);
    chk(serial_in_override, 1'b1);
    spfrx_line_model_i.send(12'h0f3, 5, 1'b0);
    repeat (400) if (irq_rx_complete !== 1'b1) @(posedge mclk);
    chk(irq_rx_complete, 1'b1);
    rdc(`SPFRX_OFF_DATA, 32'hffffffff, 32'h13);
    // four frames unread: buffer full, third waits, fourth start overruns
    wr(`SPFRX_OFF_FORMAT, 32'h03);
    for (int i = 1; i <= 4; i++) spfrx_line_model_i.send(12'(i * 8'h11), 8, 1'b0);
    rdc(`SPFRX_OFF_STATUS, 32'h9c, 32'h80);
    rdc(`SPFRX_OFF_DATA, 32'hff, 32'h11);
    rdc(`SPFRX_OFF_STATUS, 32'h88, 32'h80);
    rdc(`SPFRX_OFF_DATA, 32'hff, 32'h22);
    rdc(`SPFRX_OFF_STATUS, 32'h88, 32'h88);
    rdc(`SPFRX_OFF_DATA, 32'hff, 32'h44);
    rdc(`SPFRX_OFF_STATUS, 32'h80, 32'h0);
    // odd parity, wrong parity bit sent: error travels with the character
    wr(`SPFRX_OFF_FORMAT, 32'h1b);
    spfrx_line_model_i.send(12'h0a5, 9, 1'b0);
    rdc(`SPFRX_OFF_STATUS, 32'h94, 32'h84);
    rdc(`SPFRX_OFF_DATA, 32'hff, 32'ha5);
    // nine-bit character: ninth bit read before the low byte
    wr(`SPFRX_OFF_FORMAT, 32'h07);
    spfrx_line_model_i.send(12'h1a5, 9, 1'b0);
    repeat (400) if (irq_rx_complete !== 1'b1) @(posedge mclk);
    rdc(`SPFRX_OFF_CONTROL, 32'h40, 32'h40);
    rdc(`SPFRX_OFF_DATA, 32'hff, 32'ha5);
    // unread character lost when the receiver is switched off
    spfrx_line_model_i.send(12'h05a, 9, 1'b0);
    repeat (400) if (irq_rx_complete !== 1'b1) @(posedge mclk);
    // interrupt left enabled so only the flush can drop the request
    wr(`SPFRX_OFF_CONTROL, 32'h04);
    rdc(`SPFRX_OFF_STATUS, 32'h80, 32'h0);
    repeat (2) @(posedge mclk);
    chk(serial_in_override, 1'b0);
    wr(`SPFRX_OFF_CONTROL, 32'h05);
    rdc(`SPFRX_OFF_STATUS, 32'h80, 32'h0);
    // synchronous mode, bits clocked by the transfer clock
    wr(`SPFRX_OFF_FORMAT, 32'h43);
    spfrx_line_model_i.send(12'h06c, 8, 1'b1);
    repeat (400) if (irq_rx_complete !== 1'b1) @(posedge mclk);
    rdc(`SPFRX_OFF_DATA, 32'hff, 32'h6c);
    summarize();
  end
endmodule
`default_nettype wire
